/* rtl/ccr_pkg.sv */
// Package: register map, field layout and reset values of the calibration slice
package ccr_pkg;
    // ------------------------------------------------------------------
    // Register indices (printed offsets are not multiples of four)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CH3_GAIN_CAL_LOW    = 8'h1C;
    localparam logic [7:0] IDX_CH4_CONFIG          = 8'h1D;
    localparam logic [7:0] IDX_CH4_OFFSET_CAL_HIGH = 8'h1E;
    localparam logic [7:0] IDX_CH4_OFFSET_CAL_LOW  = 8'h1F;
    localparam logic [7:0] IDX_CH4_GAIN_CAL_HIGH   = 8'h20;
    localparam logic [7:0] IDX_CH4_GAIN_CAL_LOW    = 8'h21;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PHASE_LSB    = 6;
    localparam int PHASE_W      = 10;
    localparam int DC_OFF_BIT   = 2;
    localparam int SEL_LSB      = 0;
    localparam int SEL_W        = 2;
    localparam int LOW_BYTE_LSB = 8;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_CONFIG    = 16'h0000;
    localparam logic [15:0] RST_OFS_HIGH  = 16'h0000;
    localparam logic [7:0]  RST_LOW_BYTE  = 8'h00;
    localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
    // Input selection codes
    typedef enum logic [1:0] {
        CCR_SEL_PINS, CCR_SEL_SHORT, CCR_SEL_TEST_POS, CCR_SEL_TEST_NEG
    } ccr_sel_t;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/ccr_regs.sv */
// Calibration and configuration register slice behind an AXI4-Lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// R1: Ch3 gain low byte in bits 15:8, reset zero
// R2: Ch4 ten-bit signed phase delay, bits 15:6
// R3: Ch4 config bits 5:3 always read zero
// R4: Bit 2 disables DC block for channel 4
// R5: Bits 1:0 select pins, short, test +/-
// R6: Ch4 offset high word holds bits 23:8
// R7: Ch4 offset low byte in 15:8, rest zero
// R8: Ch4 gain high word holds bits 23:8
// R9: Ch4 gain low byte in 15:8, rest zero
// R10: Gain value is unsigned, 0.0 to under 2.0
// R11: Ch4 gain high at 20h, resets to 8000h
// R12: Ch4 config at 1Dh, resets to 0000h
// R13: Other channels share the config layout
// R14: Calibration value is high word above low byte
module ccr_regs (
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AXI4-Lite write address
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Conversion-side controls
    output logic [7:0]       ch3_gain_low_bits,
    output logic [9:0]       ch4_phase_delay,
    output logic             ch4_dc_block_off,
    output logic [1:0]       ch4_input_select,
    output logic [23:0]      ch4_offset_value,
    output logic [23:0]      ch4_gain_value
);

    // ------------------------------------------------------------------
    // Storage: only writable bits are kept
    // ------------------------------------------------------------------
    logic [7:0]  ch3_gain_low_q;
    logic [ccr_pkg::PHASE_W-1:0] ch4_phase_q;
    logic                        ch4_dc_off_q;
    logic [ccr_pkg::SEL_W-1:0]   ch4_sel_q;
    logic [15:0] ch4_offset_high_q;
    logic [7:0]  ch4_offset_low_q;
    logic [15:0] ch4_gain_high_q;
    logic [7:0]  ch4_gain_low_q;

    // ------------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------------
    logic        aw_held_q;
    logic [7:0]  aw_idx_q;
    logic        aw_bad_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic [7:0]  wr_idx;
    logic [15:0] wr_mask;
    logic        wr_hit;

    // Address and data are taken independently; each stalls once held
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_idx        = aw_idx_q;
    assign wr_mask       = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // Address slot: full from its handshake until the write lands
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    // Address capture; misaligned low bits mark the access bad
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_idx_q <= 8'h00;
            aw_bad_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_idx_q <= s_axi_awaddr[9:2];
            aw_bad_q <= |s_axi_awaddr[1:0];
        end
    end

    // Data slot: full from its handshake until the write lands
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            w_held_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Data and strobe capture; kept until the address also arrives
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    // Address decode shared by both directions
    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx >= ccr_pkg::IDX_CH3_GAIN_CAL_LOW)
                  && (idx <= ccr_pkg::IDX_CH4_GAIN_CAL_LOW);
    endfunction

    assign wr_hit = idx_mapped(wr_idx) && !aw_bad_q;

    // ------------------------------------------------------------------
    // Write selects: a refused write reaches no word
    // ------------------------------------------------------------------
    logic wr_ch3_gain_low;
    logic wr_ch4_config;
    logic wr_ch4_ofs_high;
    logic wr_ch4_ofs_low;
    logic wr_ch4_gain_high;
    logic wr_ch4_gain_low;

    // One strobe per word, raised only in the cycle the write lands
    assign wr_ch3_gain_low  = wr_fire && wr_hit && (wr_idx == ccr_pkg::IDX_CH3_GAIN_CAL_LOW);
    assign wr_ch4_config    = wr_fire && wr_hit && (wr_idx == ccr_pkg::IDX_CH4_CONFIG);
    assign wr_ch4_ofs_high  = wr_fire && wr_hit && (wr_idx == ccr_pkg::IDX_CH4_OFFSET_CAL_HIGH);
    assign wr_ch4_ofs_low   = wr_fire && wr_hit && (wr_idx == ccr_pkg::IDX_CH4_OFFSET_CAL_LOW);
    assign wr_ch4_gain_high = wr_fire && wr_hit && (wr_idx == ccr_pkg::IDX_CH4_GAIN_CAL_HIGH);
    assign wr_ch4_gain_low  = wr_fire && wr_hit && (wr_idx == ccr_pkg::IDX_CH4_GAIN_CAL_LOW);

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------

    // Response valid: rises as the write lands, held until bready
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Response code: unmapped or misaligned answers SLVERR
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bresp <= ccr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= wr_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // Register updates, one process per word and per config field; byte lanes honoured
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Channel 3 gain low byte
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch3_gain_low_q <= ccr_pkg::RST_LOW_BYTE; // R1
        end else if (wr_ch3_gain_low && w_strb_q[1]) begin
            ch3_gain_low_q <= w_data_q[15:8]; // R1
        end
    end

    // ------------------------------------------------------------------
    // Config word layout, common to every channel's config word
    // ------------------------------------------------------------------
    localparam int CFG_RSV_W = ccr_pkg::PHASE_LSB - ccr_pkg::DC_OFF_BIT - 1;
    logic [15:0] ch4_config_word;
    logic [15:0] cfg_merged;

    // Reserved field is a constant zero and has no flop, so no write reaches it
    function automatic logic [15:0] cfg_word(input logic [ccr_pkg::PHASE_W-1:0] phase,
                                             input logic                        dc_off,
                                             input logic [ccr_pkg::SEL_W-1:0]   sel);
        cfg_word = {phase, {CFG_RSV_W{1'b0}}, dc_off, sel};
    endfunction

    // Read view of the word; strobed lanes overlay it on a write
    assign ch4_config_word = cfg_word(ch4_phase_q, ch4_dc_off_q, ch4_sel_q); // R3 R13
    assign cfg_merged      = merge(ch4_config_word, w_data_q[15:0], wr_mask);

    // Phase delay spans both byte lanes; the merge keeps an unstrobed lane
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_phase_q <= ccr_pkg::RST_CONFIG[ccr_pkg::PHASE_LSB +: ccr_pkg::PHASE_W]; // R12
        end else if (wr_ch4_config) begin
            ch4_phase_q <= cfg_merged[ccr_pkg::PHASE_LSB +: ccr_pkg::PHASE_W]; // R2
        end
    end

    // DC-block disable; zero leaves the channel under the global setting
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_dc_off_q <= ccr_pkg::RST_CONFIG[ccr_pkg::DC_OFF_BIT]; // R12
        end else if (wr_ch4_config) begin
            ch4_dc_off_q <= cfg_merged[ccr_pkg::DC_OFF_BIT]; // R4
        end
    end

    // Input selection code
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_sel_q <= ccr_pkg::RST_CONFIG[ccr_pkg::SEL_LSB +: ccr_pkg::SEL_W]; // R12
        end else if (wr_ch4_config) begin
            ch4_sel_q <= cfg_merged[ccr_pkg::SEL_LSB +: ccr_pkg::SEL_W]; // R5
        end
    end

    // Channel 4 offset high word
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_offset_high_q <= ccr_pkg::RST_OFS_HIGH;
        end else if (wr_ch4_ofs_high) begin
            ch4_offset_high_q <= merge(ch4_offset_high_q, w_data_q[15:0], wr_mask); // R6
        end
    end

    // Channel 4 offset low byte
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_offset_low_q <= ccr_pkg::RST_LOW_BYTE;
        end else if (wr_ch4_ofs_low && w_strb_q[1]) begin
            ch4_offset_low_q <= w_data_q[15:8]; // R7
        end
    end

    // Channel 4 gain high word: reset gives unity gain
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_gain_high_q <= ccr_pkg::RST_GAIN_HIGH; // R11
        end else if (wr_ch4_gain_high) begin
            ch4_gain_high_q <= merge(ch4_gain_high_q, w_data_q[15:0], wr_mask); // R8
        end
    end

    // Channel 4 gain low byte
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ch4_gain_low_q <= ccr_pkg::RST_LOW_BYTE;
        end else if (wr_ch4_gain_low && w_strb_q[1]) begin
            ch4_gain_low_q <= w_data_q[15:8]; // R9
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [15:0] rd_word;
    logic [7:0]  rd_idx;
    logic        rd_ok;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[9:2];
    assign rd_ok         = idx_mapped(rd_idx) && ~|s_axi_araddr[1:0];

    // Word view; reserved low bytes are constant zero
    always_comb begin
        unique case (rd_idx)
            ccr_pkg::IDX_CH3_GAIN_CAL_LOW:    rd_word = {ch3_gain_low_q, 8'h00};
            ccr_pkg::IDX_CH4_CONFIG:          rd_word = ch4_config_word; // R3
            ccr_pkg::IDX_CH4_OFFSET_CAL_HIGH: rd_word = ch4_offset_high_q;
            ccr_pkg::IDX_CH4_OFFSET_CAL_LOW:  rd_word = {ch4_offset_low_q, 8'h00}; // R7
            ccr_pkg::IDX_CH4_GAIN_CAL_HIGH:   rd_word = ch4_gain_high_q;
            ccr_pkg::IDX_CH4_GAIN_CAL_LOW:    rd_word = {ch4_gain_low_q, 8'h00}; // R9
            default:                          rd_word = 16'h0000;
        endcase
    end

    // Read valid one cycle after the address is taken; held until rready
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read data; a refused read returns zero rather than a neighbour's word
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // Read response code: unmapped or misaligned answers SLVERR
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rresp <= ccr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rresp <= rd_ok ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // Conversion-side views; values apply from the cycle after a write
    // ------------------------------------------------------------------
    // Config fields straight from their flops, no decode in the path
    assign ch4_phase_delay  = ch4_phase_q; // R2
    assign ch4_dc_block_off = ch4_dc_off_q; // R4
    assign ch4_input_select = ch4_sel_q; // R5
    assign ch3_gain_low_bits = ch3_gain_low_q;
    // Unsigned gain: 800000h is unity, full scale just under two
    assign ch4_gain_value   = {ch4_gain_high_q, ch4_gain_low_q}; // R10 R14
    assign ch4_offset_value = {ch4_offset_high_q, ch4_offset_low_q}; // R14

endmodule // ccr_regs

/* tb/ccr_checker.sv */
// Checker: bus answer timing and read-back relations of the calibration slice
`timescale 1ns/1ps
module ccr_checker (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        ch4_dc_block_off,
    input wire logic [9:0]  s_axi_awaddr,
    input wire logic [9:0]  s_axi_araddr,
    input wire logic [9:0]  ch4_phase_delay,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [1:0]  ch4_input_select,
    input wire logic [7:0]  ch3_gain_low_bits,
    input wire logic [23:0] ch4_offset_value,
    input wire logic [23:0] ch4_gain_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address of the read in flight; rvalid blocks a new one, so it stays valid
    logic [9:0] ra_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) ra_q <= 10'h000;
        else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
    end
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_ans(a);
        s_axi_rvalid && ra_q == a;
    endsequence
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    reset_values_a: assert property ($rose(rstn) |->
        ch4_gain_value == 24'h800000 && ch4_offset_value == 24'h000000
        && ch3_gain_low_bits == 8'h00 && ch4_phase_delay == 10'h000
        && !ch4_dc_block_off && ch4_input_select == 2'h0) else $error("bad reset");
    // Taken at N, landed at N+1, so the answer is first seen at N+2
    write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("no bvalid");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rvalid");
    sel_write_a: assert property (wr_take ##0 (s_axi_awaddr == 10'h074)
        ##0 s_axi_wstrb[0] |-> ##2 (ch4_input_select == $past(s_axi_wdata[1:0], 2)
        && ch4_dc_block_off == $past(s_axi_wdata[2], 2))) else $error("config not applied");
    unmapped_err_a: assert property (wr_take ##0 (s_axi_awaddr == 10'h0C0) |->
        ##2 (s_axi_bvalid && s_axi_bresp == ccr_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");
    read_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == ccr_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("misaligned read not refused");
    cfg_read_a: assert property (rd_ans(10'h074) |-> s_axi_rdata ==
        {16'h0000, ch4_phase_delay, 3'h0, ch4_dc_block_off, ch4_input_select}) else $error("cfg");
    low_rsv_a: assert property (s_axi_rvalid && ra_q inside {10'h070, 10'h07C, 10'h084} |->
        s_axi_rdata[7:0] == 8'h00) else $error("reserved byte not zero");
    ofs_read_a: assert property (rd_ans(10'h078) |->
        s_axi_rdata[15:0] == ch4_offset_value[23:8]) else $error("offset high mismatch");
    gain_high_a: assert property (rd_ans(10'h080) |->
        s_axi_rdata[15:0] == ch4_gain_value[23:8]) else $error("gain high mismatch");
    gain_low_a: assert property (rd_ans(10'h084) |->
        s_axi_rdata[15:8] == ch4_gain_value[7:0]) else $error("gain low mismatch");
    ch3_read_a: assert property (rd_ans(10'h070) |->
        s_axi_rdata == {16'h0000, ch3_gain_low_bits, 8'h00}) else $error("ch3 low mismatch");
endmodule // ccr_checker
bind ccr_regs ccr_checker ccr_checker_i (.mclk(mclk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ch4_dc_block_off(ch4_dc_block_off), .s_axi_awaddr(s_axi_awaddr), .s_axi_araddr(s_axi_araddr),
    .ch4_phase_delay(ch4_phase_delay), .s_axi_wdata(s_axi_wdata), .s_axi_rdata(s_axi_rdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
    .ch4_input_select(ch4_input_select), .ch3_gain_low_bits(ch3_gain_low_bits),
    .ch4_offset_value(ch4_offset_value), .ch4_gain_value(ch4_gain_value));

/* tb/tb_channel_cal_config_regs.sv */
// Testbench: register table, field behaviour and bus answers of the calibration slice
`timescale 1ns/1ps
module tb_channel_cal_config_regs;
    typedef struct packed {logic [7:0] idx; logic [15:0] dat; logic [3:0] stb;
                           logic [15:0] exp; logic [1:0] rsp;} ccr_row_t;
    logic mclk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dc_off;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000, phase;
    logic [31:0] wdata = 32'h00000000, rdata, d;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, sel, r;
    logic [7:0]  ch3;
    logic [23:0] ofs, gain;
    int num_errors = 0, n_compared = 0;
    // Row 6 writes only the low byte, so the phase from row 5 must survive
    localparam ccr_row_t ROWS [11] = '{'{8'h1C, 16'hFFFF, 4'h3, 16'hFF00, 2'h0},
        '{8'h1D, 16'hFFFF, 4'h3, 16'hFFC7, 2'h0}, '{8'h1D, 16'h0040, 4'h3, 16'h0040, 2'h0},
        '{8'h1D, 16'h0005, 4'h3, 16'h0005, 2'h0}, '{8'h1D, 16'h8002, 4'h3, 16'h8002, 2'h0},
        '{8'h1D, 16'h0003, 4'h1, 16'h8003, 2'h0}, '{8'h1E, 16'hA5C3, 4'h3, 16'hA5C3, 2'h0},
        '{8'h1F, 16'hFFFF, 4'h3, 16'hFF00, 2'h0}, '{8'h20, 16'h1234, 4'h3, 16'h1234, 2'h0},
        '{8'h21, 16'hABCD, 4'h3, 16'hAB00, 2'h0}, '{8'h30, 16'hFFFF, 4'h3, 16'h0000, 2'h2}};
    always #50 mclk = ~mclk;
    ccr_regs ccr_regs_i (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ch3_gain_low_bits(ch3), .ch4_phase_delay(phase), .ch4_dc_block_off(dc_off),
        .ch4_input_select(sel), .ch4_offset_value(ofs), .ch4_gain_value(gain));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together; each released once taken
    task automatic wr(input logic [9:0] a, input logic [15:0] v, input logic [3:0] s);
        bit ad = 0, wd = 0;
        @(posedge mclk);
        awaddr <= a; awv <= 1'b1; wdata <= {16'h0000, v}; wstrb <= s; wv <= 1'b1; bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge mclk);
            if (!ad && awready === 1'b1) begin ad = 1; awv <= 1'b0; end
            if (!wd && wready === 1'b1) begin wd = 1; wv <= 1'b0; end
        end
        do @(posedge mclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge mclk);
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        d = rdata; r = rresp;
        rready <= 1'b0;
    endtask
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 8'h1C; i <= 8'h21; i++) begin
            rd(10'(4 * i));
            chk(d, (i == 8'h20) ? 32'h00008000 : 32'h00000000);
        end
        $display("Reset values done");
        foreach (ROWS[i]) begin
            wr(10'(4 * ROWS[i].idx), ROWS[i].dat, ROWS[i].stb);
            chk(r, ROWS[i].rsp);
            rd(10'(4 * ROWS[i].idx));
            chk(d, ROWS[i].exp);
            chk(r, ROWS[i].rsp);
        end
        chk({phase, dc_off, sel}, {10'h200, 1'b0, 2'h3});
        chk({ofs, ch3}, {24'hA5C3FF, 8'hFF});
        chk(gain, 24'h1234AB);
        $display("Row table done");
        rd(10'h075);
        chk(d, 32'h00000000);
        chk(r, ccr_pkg::RESP_SLVERR);
        // Misaligned write is refused and leaves the config word alone
        wr(10'h076, 16'hFFFF, 4'h3);
        chk(r, ccr_pkg::RESP_SLVERR);
        rd(10'h074);
        chk(d, 32'h00008003);
        // Reset in mid-run must bring back unity gain
        @(posedge mclk) rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        chk(gain, 24'h800000);
        chk({ofs, ch3}, 32'h00000000);
        chk({phase, dc_off, sel}, {10'h000, 1'b0, 2'h0});
        rd(10'h074);
        chk(d, 32'h00000000);
        $display("Refusal and reset done");
        finish_test();
    end
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
endmodule // tb_channel_cal_config_regs
